//--- design/timer_capture_pkg.sv
/*
   Package for the 16-bit timer with input capture.
   Holds register indices, field positions, reset values and mode codes.
   Assumes a plain register port with read data one cycle after the strobe.
*/
package timer_capture_pkg;

   // ----------------------------------------------------------------
   // Register map (indices on the plain register port)
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_TIMER_B_CONTROL   = 3'h0;
   localparam logic [2:0] ADDR_TIMER_B_COUNT     = 3'h1;
   localparam logic [2:0] ADDR_CAPTURE_CONTROL   = 3'h2;
   localparam logic [2:0] ADDR_CAPTURE_BUFFER    = 3'h3;
   localparam logic [2:0] ADDR_COMPANION_CONTROL = 3'h4;

   // ----------------------------------------------------------------
   // Timer control fields
   // ----------------------------------------------------------------
   localparam int          TCTL_RUN_BIT     = 15;
   localparam int          TCTL_IDLE_BIT    = 13;
   localparam int          TCTL_GATE_BIT    = 6;
   localparam int          TCTL_PS_HI       = 5;
   localparam int          TCTL_PS_LO       = 4;
   localparam int          TCTL_SRC_BIT     = 1;
   localparam logic [15:0] TCTL_WRITE_MASK  = 16'hA072;
   localparam logic [15:0] TCTL_RESET       = 16'h0000;
   localparam int          COMP_PAIR_BIT    = 3;

   // ----------------------------------------------------------------
   // Capture control fields
   // ----------------------------------------------------------------
   localparam int          CCTL_IDLE_BIT    = 13;
   localparam int          CCTL_TB_BIT      = 7;
   localparam int          CCTL_ICI_HI      = 6;
   localparam int          CCTL_ICI_LO      = 5;
   localparam int          CCTL_OV_BIT      = 4;
   localparam int          CCTL_NE_BIT      = 3;
   localparam logic [15:0] CCTL_WRITE_MASK  = 16'h20E7;
   localparam logic [15:0] CCTL_RESET       = 16'h0000;

   // ----------------------------------------------------------------
   // Timing and sizes
   // ----------------------------------------------------------------
   localparam int          FOSC_HALF_DIV    = 2;
   localparam int          FIFO_DEPTH       = 4;
   localparam logic [7:0]  PS_DIV_256       = 8'hFF;
   localparam logic [7:0]  PS_DIV_64        = 8'h3F;
   localparam logic [7:0]  PS_DIV_8         = 8'h07;
   localparam logic [7:0]  PS_DIV_1         = 8'h00;
   localparam logic [3:0]  CAP_DIV_16       = 4'hF;
   localparam logic [3:0]  CAP_DIV_4        = 4'h3;

   typedef enum logic [2:0] {
      CAP_OFF     = 3'h0,
      CAP_EVERY   = 3'h1,
      CAP_FALL    = 3'h2,
      CAP_RISE    = 3'h3,
      CAP_RISE4   = 3'h4,
      CAP_RISE16  = 3'h5,
      CAP_UNUSED  = 3'h6,
      CAP_WAKE    = 3'h7
   } cap_mode_t;

   typedef struct packed {
      logic [2:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_t;

   typedef struct packed {
      logic        idle;
      logic        sleep;
   } power_state_t;

endpackage

//--- design/timer_prescaler.sv
/*
   Timer input selection, gating and prescaler for the 16-bit timer.
   Assumes all inputs are synchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
   import timer_capture_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Control
   input  wire logic       run,
   input  wire logic       halt,
   input  wire logic       gate_en,
   input  wire logic       src_ext,
   input  wire logic [1:0] ps_sel,
   // Pins
   input  wire logic       ext_pin,
   input  wire logic       gate_in,
   // Result
   output logic            tick
);

   logic       half_reg;
   logic       ext_prev_reg;
   logic [7:0] ps_cnt_reg;
   logic [7:0] ps_limit;
   logic       raw_tick;

   always_comb begin
      unique case (ps_sel)                                       // [RULE3]
         2'b11:   ps_limit = PS_DIV_256;
         2'b10:   ps_limit = PS_DIV_64;
         2'b01:   ps_limit = PS_DIV_8;
         default: ps_limit = PS_DIV_1;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         half_reg     <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         half_reg     <= ~half_reg;
         ext_prev_reg <= ext_pin;
      end
   end

   // Gate is ignored entirely with the external source
   always_comb begin
      if (src_ext)
         raw_tick = ext_pin & ~ext_prev_reg;                     // [RULE4] [RULE1]
      else
         raw_tick = half_reg & (~gate_en | gate_in);             // [RULE5] [RULE2]
   end

   always_ff @(posedge clk_sys) begin
      if (rst || !run)
         ps_cnt_reg <= 8'h00;
      else if (raw_tick && !halt) begin
         if (ps_cnt_reg >= ps_limit)
            ps_cnt_reg <= 8'h00;
         else
            ps_cnt_reg <= ps_cnt_reg + 8'h01;
      end
   end

   assign tick = run && !halt && raw_tick && (ps_cnt_reg >= ps_limit); // [RULE22] [RULE21]

endmodule // timer_prescaler
`default_nettype wire

//--- design/capture_fifo.sv
/*
   Four-entry capture queue with overflow detection.
   Assumes push and pop are single-cycle pulses on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_fifo
   import timer_capture_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        flush,
   // Write side
   input  wire logic        push,
   input  wire logic [15:0] push_data,
   // Read side
   input  wire logic        pop,
   output logic [15:0]      head,
   output logic             not_empty,
   output logic             overflow
);

   logic [15:0] mem [FIFO_DEPTH];
   logic [1:0]  wp_reg;
   logic [1:0]  rp_reg;
   logic [2:0]  cnt_reg;
   logic        ov_reg;
   logic        do_push;
   logic        do_pop;

   assign do_pop  = pop && (cnt_reg != 3'h0);
   // A capture into a full queue is dropped and flagged unless a pop in the same cycle frees an entry
   assign do_push = push && (cnt_reg != 3'h4 || do_pop);

   always_ff @(posedge clk_sys) begin
      if (do_push)
         mem[wp_reg] <= push_data;                               // [RULE15]
   end

   always_ff @(posedge clk_sys) begin
      if (rst || flush) begin
         wp_reg  <= 2'h0;
         rp_reg  <= 2'h0;
         cnt_reg <= 3'h0;
      end else begin
         if (do_push)
            wp_reg <= wp_reg + 2'h1;
         if (do_pop)
            rp_reg <= rp_reg + 2'h1;
         cnt_reg <= cnt_reg + {2'h0, do_push} - {2'h0, do_pop};
      end
   end

   // Overflow clears only once the queue drains or the unit is off
   always_ff @(posedge clk_sys) begin
      if (rst || flush)
         ov_reg <= 1'b0;
      else if (push && !do_push)
         ov_reg <= 1'b1;                                         // [RULE20]
      else if (cnt_reg == 3'h0)
         ov_reg <= 1'b0;
   end

   assign head      = mem[rp_reg];
   assign not_empty = (cnt_reg != 3'h0);                        // [RULE20]
   assign overflow  = ov_reg;

   chk_overflow_full: assert property (@(posedge clk_sys) disable iff (rst) // [RULE20]
      (push && cnt_reg == 3'h4 && !pop && !flush) |=> ov_reg)
      else $error("overflow not flagged on full push");

endmodule // capture_fifo
`default_nettype wire

//--- design/timer_with_input_capture.sv
/*
   16-bit timer with a single input capture channel and four-entry queue.
   Assumes synchronous pins, a plain register port and external power state.
*/
// Summary of operation
// [RULE1] - External source ignores the gate enable bit.
// [RULE2] - Internal source with gate set counts only while gate input high.
// [RULE3] - Prescale codes 11,10,01,00 divide by 256,64,8,1.
// [RULE4] - Source bit 1 counts rising edges of external count pin.
// [RULE5] - Source bit 0 counts the internal half-rate clock.
// [RULE6] - Wide pairing bit makes companion control govern this timer.
// [RULE7] - Unimplemented timer control bits read zero, writes ignored.
// [RULE8] - A pin event latches one of two selectable timer counts.
// [RULE9] - Exactly one capture channel, mode set by its control register.
// [RULE10] - Falling mode captures every high-to-low pin transition.
// [RULE11] - Rising mode captures every low-to-high pin transition.
// [RULE12] - Prescaled modes capture every 4th or 16th rising edge.
// [RULE13] - Both-edge mode captures every rising and falling transition.
// [RULE14] - Capture pin can wake the CPU from Sleep and Idle.
// [RULE15] - Captures queue in a four-deep FIFO read in order.
// [RULE16] - Interrupt raised after a selected number of captures.
// [RULE17] - Mode field encodes off, edge, fall, rise, 4th, 16th, unused, wake.
// [RULE18] - Captures-per-interrupt codes 00..11 mean 1..4; ignored in every-edge.
// [RULE19] - Timebase bit 1 picks companion count, 0 this timer's count.
// [RULE20] - Overflow and not-empty flags are read-only, hardware cleared.
// [RULE21] - Idle-stop bit freezes count during Idle.
// [RULE22] - Count advances only while run bit 15 is set.
`timescale 1ns/1ps
`default_nettype none
module timer_with_input_capture
   import timer_capture_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // Register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [15:0]      reg_rdata,
   // Companion timer
   input  wire logic [15:0] companion_timer_count,
   // Pins
   input  wire logic        external_count_pin,
   input  wire logic        gate_pin,
   input  wire logic        capture_input_pin,
   // Power state
   input  wire logic        cpu_idle,
   input  wire logic        cpu_sleep,
   // Events
   output logic             capture_irq,
   output logic             wake_request
);

   reg_req_t     req;
   power_state_t pwr;
   logic [15:0]  timer_b_control_reg;
   logic [15:0]  companion_timer_control_reg;
   logic [15:0]  capture_control_reg;
   logic [15:0]  timer_b_count_reg;
   logic [15:0]  eff_ctl;
   logic         tick;
   logic         pin_prev_reg;
   logic         rise;
   logic         fall;
   logic [3:0]   edge_cnt_reg;
   logic         cap_event;
   logic [1:0]   irq_cnt_reg;
   logic         irq_reg;
   logic         wake_reg;
   logic [15:0]  fifo_head;
   logic         fifo_ne;
   logic         fifo_ov;
   logic         fifo_pop;
   logic         cap_flush;
   cap_mode_t    mode;

   assign req  = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign pwr  = '{idle: cpu_idle, sleep: cpu_sleep};
   assign mode = cap_mode_t'(capture_control_reg[2:0]);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst)
         timer_b_control_reg <= TCTL_RESET;
      else if (req.wr && req.addr == ADDR_TIMER_B_CONTROL)
         timer_b_control_reg <= req.wdata & TCTL_WRITE_MASK;     // [RULE7]
   end

   // Companion control is mirrored here so the pairing override is visible
   always_ff @(posedge clk_sys) begin
      if (rst)
         companion_timer_control_reg <= TCTL_RESET;
      else if (req.wr && req.addr == ADDR_COMPANION_CONTROL)
         companion_timer_control_reg <= req.wdata & (TCTL_WRITE_MASK | 16'h0008);
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         capture_control_reg <= CCTL_RESET;
      else if (req.wr && req.addr == ADDR_CAPTURE_CONTROL)
         capture_control_reg <= req.wdata & CCTL_WRITE_MASK;     // [RULE9]
   end

   // ----------------------------------------------------------------
   // Timer
   // ----------------------------------------------------------------
   assign eff_ctl = companion_timer_control_reg[COMP_PAIR_BIT] ?
                    companion_timer_control_reg : timer_b_control_reg; // [RULE6]

   timer_prescaler u_prescaler (
      .clk_sys (clk_sys),
      .rst     (rst),
      .run     (eff_ctl[TCTL_RUN_BIT]),
      .halt    (eff_ctl[TCTL_IDLE_BIT] && pwr.idle),
      .gate_en (eff_ctl[TCTL_GATE_BIT]),
      .src_ext (eff_ctl[TCTL_SRC_BIT]),
      .ps_sel  (eff_ctl[TCTL_PS_HI:TCTL_PS_LO]),
      .ext_pin (external_count_pin),
      .gate_in (gate_pin),
      .tick    (tick)
   );

   always_ff @(posedge clk_sys) begin
      if (rst)
         timer_b_count_reg <= 16'h0000;
      else if (req.wr && req.addr == ADDR_TIMER_B_COUNT)
         timer_b_count_reg <= req.wdata;
      else if (tick)
         timer_b_count_reg <= timer_b_count_reg + 16'h0001;      // [RULE22]
   end

   // ----------------------------------------------------------------
   // Capture edge detection
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst)
         pin_prev_reg <= 1'b0;
      else
         pin_prev_reg <= capture_input_pin;
   end

   assign rise = capture_input_pin & ~pin_prev_reg;
   assign fall = ~capture_input_pin & pin_prev_reg;

   // Idle stop of the capture unit flushes it as if turned off
   assign cap_flush = (mode == CAP_OFF) || (mode == CAP_UNUSED) ||
                      (capture_control_reg[CCTL_IDLE_BIT] && pwr.idle);

   always_ff @(posedge clk_sys) begin
      if (rst || cap_flush || (mode != CAP_RISE4 && mode != CAP_RISE16))
         edge_cnt_reg <= 4'h0;
      else if (rise) begin
         if ((mode == CAP_RISE4 && edge_cnt_reg == CAP_DIV_4) ||
             (mode == CAP_RISE16 && edge_cnt_reg == CAP_DIV_16))
            edge_cnt_reg <= 4'h0;
         else
            edge_cnt_reg <= edge_cnt_reg + 4'h1;                 // [RULE12]
      end
   end

   always_comb begin
      cap_event = 1'b0;
      if (!cap_flush) begin
         unique case (mode)                                      // [RULE17]
            CAP_EVERY:  cap_event = rise | fall;                 // [RULE13]
            CAP_FALL:   cap_event = fall;                        // [RULE10]
            CAP_RISE:   cap_event = rise;                        // [RULE11]
            CAP_RISE4:  cap_event = rise && edge_cnt_reg == CAP_DIV_4;  // [RULE12]
            CAP_RISE16: cap_event = rise && edge_cnt_reg == CAP_DIV_16; // [RULE12]
            default:    cap_event = 1'b0;
         endcase
      end
   end

   assign fifo_pop = req.rd && req.addr == ADDR_CAPTURE_BUFFER;

   capture_fifo u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .flush     (cap_flush),
      .push      (cap_event),
      .push_data (capture_control_reg[CCTL_TB_BIT] ?
                  companion_timer_count : timer_b_count_reg),   // [RULE8] [RULE19]
      .pop       (fifo_pop),
      .head      (fifo_head),
      .not_empty (fifo_ne),
      .overflow  (fifo_ov)
   );

   // ----------------------------------------------------------------
   // Interrupt and wake
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst || cap_flush)
         irq_cnt_reg <= 2'h0;
      else if (cap_event) begin
         if (mode == CAP_EVERY ||
             irq_cnt_reg == capture_control_reg[CCTL_ICI_HI:CCTL_ICI_LO])
            irq_cnt_reg <= 2'h0;
         else
            irq_cnt_reg <= irq_cnt_reg + 2'h1;                   // [RULE16]
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         irq_reg <= 1'b0;
      else
         irq_reg <= cap_event && (mode == CAP_EVERY ||
                    irq_cnt_reg == capture_control_reg[CCTL_ICI_HI:CCTL_ICI_LO]); // [RULE16] [RULE18]
   end

   always_ff @(posedge clk_sys) begin
      if (rst)
         wake_reg <= 1'b0;
      else
         wake_reg <= mode == CAP_WAKE && rise && (pwr.idle || pwr.sleep); // [RULE14]
   end

   assign capture_irq  = irq_reg | wake_reg;
   assign wake_request = wake_reg;

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst)
         reg_rdata <= 16'h0000;
      else if (req.rd) begin
         unique case (req.addr)
            ADDR_TIMER_B_CONTROL:   reg_rdata <= timer_b_control_reg; // [RULE7]
            ADDR_TIMER_B_COUNT:     reg_rdata <= timer_b_count_reg;
            ADDR_CAPTURE_CONTROL:   reg_rdata <= {capture_control_reg[15:5], fifo_ov,
                                                 fifo_ne, capture_control_reg[2:0]}; // [RULE20]
            ADDR_CAPTURE_BUFFER:    reg_rdata <= fifo_head;       // [RULE15]
            ADDR_COMPANION_CONTROL: reg_rdata <= companion_timer_control_reg;
            default:                reg_rdata <= 16'h0000;
         endcase
      end else
         reg_rdata <= 16'h0000;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence s_cap_fall;
      !cap_flush && mode == CAP_FALL && fall;
   endsequence

   chk_fall_capture: assert property (@(posedge clk_sys) disable iff (rst) // [RULE10]
      s_cap_fall |-> cap_event)
      else $error("falling edge not captured");

   chk_rise_capture: assert property (@(posedge clk_sys) disable iff (rst) // [RULE11]
      (!cap_flush && mode == CAP_RISE) |-> (cap_event == rise))
      else $error("rise mode capture mismatch");

   chk_every_edge: assert property (@(posedge clk_sys) disable iff (rst) // [RULE13]
      (!cap_flush && mode == CAP_EVERY && (rise || fall)) |-> cap_event)
      else $error("both-edge capture missed");

   chk_run_halt: assert property (@(posedge clk_sys) disable iff (rst) // [RULE22]
      (!eff_ctl[TCTL_RUN_BIT] && !(req.wr && req.addr == ADDR_TIMER_B_COUNT))
      |=> $stable(timer_b_count_reg))
      else $error("count moved while halted");

   chk_idle_freeze: assert property (@(posedge clk_sys) disable iff (rst) // [RULE21]
      (eff_ctl[TCTL_IDLE_BIT] && pwr.idle) |-> !tick)
      else $error("timer ticked in idle stop");

   chk_ctl_unimpl: assert property (@(posedge clk_sys) disable iff (rst) // [RULE7]
      (timer_b_control_reg & ~TCTL_WRITE_MASK) == 16'h0000)
      else $error("unimplemented control bit set");

   chk_irq_single: assert property (@(posedge clk_sys) disable iff (rst) // [RULE16]
      (cap_event && mode != CAP_EVERY &&
       capture_control_reg[CCTL_ICI_HI:CCTL_ICI_LO] == 2'h3 && irq_cnt_reg != 2'h3) |=> !irq_reg)
      else $error("interrupt before count reached");

   chk_wake_sleep: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
      (mode == CAP_WAKE && rise && pwr.sleep) |=> wake_request)
      else $error("wake not raised");

   chk_wake_awake: assert property (@(posedge clk_sys) disable iff (rst) // [RULE14]
      (!pwr.idle && !pwr.sleep) |=> !wake_request)
      else $error("wake raised while awake");

   chk_gate_hold: assert property (@(posedge clk_sys) disable iff (rst) // [RULE2]
      (!eff_ctl[TCTL_SRC_BIT] && eff_ctl[TCTL_GATE_BIT] && !gate_pin) |-> !tick)
      else $error("timer ticked with gate low");

   chk_div4_early: assert property (@(posedge clk_sys) disable iff (rst) // [RULE12]
      (mode == CAP_RISE4 && edge_cnt_reg != CAP_DIV_4) |-> !cap_event)
      else $error("prescaled capture too early");

   chk_irq_every: assert property (@(posedge clk_sys) disable iff (rst) // [RULE18]
      (cap_event && mode == CAP_EVERY) |=> capture_irq)
      else $error("every-edge capture without interrupt");

   chk_pair_stop: assert property (@(posedge clk_sys) disable iff (rst) // [RULE6]
      (companion_timer_control_reg[COMP_PAIR_BIT] && !companion_timer_control_reg[TCTL_RUN_BIT]) |-> !tick)
      else $error("paired timer ticked without companion run");

endmodule // timer_with_input_capture
`default_nettype wire

//--- testbench/capture_pins.sv
/*
   Far-side pin model: capture pin, external count pin, gate pin, companion count.
   Assumes pins are sampled on clk_sys; every level is held four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module capture_pins (
   // Clock
   input  wire logic        clk_sys,
   // Pins
   output var  logic        capture_input_pin,
   output var  logic        external_count_pin,
   output var  logic        gate_pin,
   output var  logic [15:0] companion_timer_count
);
   initial begin
      capture_input_pin     = 1'b0;
      external_count_pin    = 1'b0;
      gate_pin              = 1'b0;
      companion_timer_count = 16'h0000;
   end
   // Four clocks per level keeps every edge clear of the one-clock edge detectors
   task automatic cap_pulse(input logic [15:0] val);
      @(posedge clk_sys) companion_timer_count <= val;
      @(posedge clk_sys) capture_input_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      capture_input_pin <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic ext_pulse(input int n);
      repeat (n) begin
         @(posedge clk_sys) external_count_pin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         external_count_pin <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
   endtask
endmodule // capture_pins
`default_nettype wire

//--- testbench/timer_with_input_capture_test.sv
/*
   Self-checking bench for the timer with input capture.
   Assumes the register port answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module timer_with_input_capture_test;
   import timer_capture_pkg::*;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic clk_sys, rst, reg_wr, reg_rd, cpu_idle, cpu_sleep, cap, ext, gate;
   logic capture_irq, wake_request;
   logic [2:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, comp, v, r;
   int n_mismatch, checked, cycles, n_irq, n_wake;
   capture_pins u_pins (.clk_sys(clk_sys), .capture_input_pin(cap), .external_count_pin(ext),
      .gate_pin(gate), .companion_timer_count(comp));
   timer_with_input_capture u_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .companion_timer_count(comp), .external_count_pin(ext), .gate_pin(gate),
      .capture_input_pin(cap), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
      .capture_irq(capture_irq), .wake_request(wake_request));
   // ----------------------------------------------------------------
   // Clock, event counters, timeout
   // ----------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (capture_irq === 1'b1) n_irq++;
      if (wake_request === 1'b1) n_wake++;
      if (cycles == 30000) begin
         n_mismatch++;
         results();
      end
   end
   task automatic results();
      if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // Register port tasks
   // ----------------------------------------------------------------
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clk_sys) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      @(posedge clk_sys) begin reg_rd <= 1'b1; reg_addr <= a; end
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Mode table: mode, ici, pulses, expected irqs
   logic [2:0] tm [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h7};
   logic [1:0] ti [8] = '{2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
   int tp [8] = '{2, 2, 2, 16, 16, 4, 4, 3};
   int te [8] = '{4, 2, 2, 1, 1, 0, 0, 3};
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      n_mismatch = 0; checked = 0; cycles = 0; n_irq = 0; n_wake = 0;
      rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 3'h0; reg_wdata = 16'h0000;
      cpu_idle = 1'b0; cpu_sleep = 1'b0;
      idle(2);
      rst <= 1'b0;
      rd(ADDR_TIMER_B_CONTROL, r); `CHK(r, 16'h0000)
      rd(ADDR_CAPTURE_CONTROL, r); `CHK(r, 16'h0000)
      // Prescale 1:8 on external edges, run first so no residue
      wr(ADDR_TIMER_B_CONTROL, 16'h8012);
      u_pins.ext_pulse(16);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r, 16'h0002)
      // External source with gate bit set and gate low still counts
      wr(ADDR_TIMER_B_CONTROL, 16'h0000);
      wr(ADDR_TIMER_B_COUNT, 16'h0000);
      wr(ADDR_TIMER_B_CONTROL, 16'h8042);
      u_pins.ext_pulse(5);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r, 16'h0005)
      wr(ADDR_TIMER_B_CONTROL, 16'hFFFF);
      rd(ADDR_TIMER_B_CONTROL, r); `CHK(r, 16'hA072)
      wr(ADDR_TIMER_B_CONTROL, 16'h0000);
      wr(ADDR_TIMER_B_COUNT, 16'h0000);
      // Internal source ticks every other clock; start/stop phase gives slack
      wr(ADDR_TIMER_B_CONTROL, 16'h8000);
      idle(198);
      wr(ADDR_TIMER_B_CONTROL, 16'h0000);
      rd(ADDR_TIMER_B_COUNT, v); `CHK(v >= 16'd98 && v <= 16'd102, 1'b1)
      idle(20);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r, v)
      // Gate low, idle freeze, and pairing each hold the count
      wr(ADDR_TIMER_B_CONTROL, 16'h8040);
      idle(100);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r, v)
      u_pins.gate_pin <= 1'b1;
      idle(100);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r > v, 1'b1)
      wr(ADDR_TIMER_B_CONTROL, 16'hA000);
      rd(ADDR_TIMER_B_COUNT, v);
      cpu_idle <= 1'b1;
      idle(100);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r - v <= 16'h0001, 1'b1)
      wr(ADDR_TIMER_B_CONTROL, 16'h8000);
      idle(20);
      rd(ADDR_TIMER_B_COUNT, v); `CHK(v > r, 1'b1)
      cpu_idle <= 1'b0;
      wr(ADDR_COMPANION_CONTROL, 16'h0008);
      wr(ADDR_TIMER_B_CONTROL, 16'h8000);
      rd(ADDR_TIMER_B_COUNT, v);
      idle(100);
      rd(ADDR_TIMER_B_COUNT, r); `CHK(r, v)
      wr(ADDR_COMPANION_CONTROL, 16'h0000);
      // Capture of own count with timebase bit clear
      wr(ADDR_TIMER_B_CONTROL, 16'h0000);
      wr(ADDR_TIMER_B_COUNT, 16'h1234);
      wr(ADDR_CAPTURE_CONTROL, 16'h0003);
      u_pins.cap_pulse(16'h0000);
      rd(ADDR_CAPTURE_BUFFER, r); `CHK(r, 16'h1234)
      // Five rising captures of companion count, every second interrupts
      wr(ADDR_CAPTURE_CONTROL, 16'h0000);
      wr(ADDR_CAPTURE_CONTROL, 16'h00BB);
      n_irq = 0;
      for (int i = 0; i < 5; i++) u_pins.cap_pulse(16'h0100 + 16'(i));
      `CHK(n_irq, 2)
      rd(ADDR_CAPTURE_CONTROL, r); `CHK(r, 16'h00BB)
      for (int i = 0; i < 4; i++) begin
         rd(ADDR_CAPTURE_BUFFER, r); `CHK(r, 16'h0100 + 16'(i))
      end
      rd(ADDR_CAPTURE_CONTROL, r); `CHK(r, 16'h00A3)
      rd(3'h6, r); `CHK(r, 16'h0000)
      // Capture idle stop: no capture is queued while the CPU idles
      wr(ADDR_CAPTURE_CONTROL, 16'h2003);
      cpu_idle <= 1'b1;
      u_pins.cap_pulse(16'h0000);
      cpu_idle <= 1'b0;
      rd(ADDR_CAPTURE_CONTROL, r); `CHK(r, 16'h2003)
      // Every mode code in turn, restarted from off each time
      for (int m = 0; m < 8; m++) begin
         wr(ADDR_CAPTURE_CONTROL, 16'h0000);
         cpu_sleep <= (m == 7);
         wr(ADDR_CAPTURE_CONTROL, {9'h000, ti[m], 2'h0, tm[m]});
         n_irq = 0;
         n_wake = 0;
         for (int p = 0; p < tp[m]; p++) u_pins.cap_pulse(16'h0200);
         idle(2);
         `CHK(n_irq, te[m])
         `CHK(n_wake, (m == 7) ? 3 : 0)
      end
      results();
   end
endmodule // timer_with_input_capture_test
`default_nettype wire
